// *** hdl/ism_consts.svh ***
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH
// register byte addresses
`define ISM_ADR_SMC     8'h00
`define ISM_ADR_EDGE    8'h04
`define ISM_ADR_PIC0    8'h08
`define ISM_ADR_PIC1    8'h0C
`define ISM_ADR_PIC2    8'h10
`define ISM_ADR_GIC0    8'h14
`define ISM_ADR_GIC1    8'h18
`define ISM_ADR_GIC2    8'h1C
`define ISM_ADR_GIC3    8'h20
`define ISM_ADR_SERCFG  8'h24
`define ISM_ADR_STAT    8'h28
// field positions and masks
`define ISM_SMC_OUT     5
`define ISM_SMC_EN      4
`define ISM_SMC_WMASK   8'h17
`define ISM_EDGE_WMASK  8'h0F
`define ISM_PIC0_MASK   8'h7F
`define ISM_GIC_MASK    8'h33
`define ISM_PIC2_MASK   8'h33
`define ISM_SER_MASK    8'h0F
`define ISM_RST_VAL     8'h00
// timing
`define ISM_CLK_HZ      40000000
`define ISM_RECOVER_NS  1000
`define ISM_RECOVER_CYC ((`ISM_RECOVER_NS * 40 + 999) / 1000)
`define ISM_DEBOUNCE_LS 4
`endif

// *** hdl/ism_pkg.sv ***
package ism_pkg;
    typedef enum logic [1:0] {
        ISM_RUN,
        ISM_ASLEEP,
        ISM_RECOVER
    } ism_pwr_t;
    typedef enum logic [1:0] {
        ISM_EDGE_OFF,
        ISM_EDGE_RISE,
        ISM_EDGE_FALL,
        ISM_EDGE_BOTH
    } ism_edge_t;
endpackage : ism_pkg

// *** hdl/ism_sync_if.sv ***
`timescale 1ns/10ps
interface ism_sync_if;
    logic [4:0] rawIn;
    logic [4:0] cleanOut;
    modport owner (output rawIn, input cleanOut);
    modport sync  (input rawIn, output cleanOut);
endinterface : ism_sync_if

// *** hdl/ism_pin_sync.sv ***
`timescale 1ns/10ps
module ism_pin_sync
    import ism_pkg::*;
(
    // clock and reset
    input wire logic     ref_clk,
    input wire logic     rst,
    // pins
    ism_sync_if.sync     pins
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] val;
    } ism_sync_st_t;

    ism_sync_st_t st_ff;
    ism_sync_st_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pins.rawIn;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // accept a change once stage two and three agree
        for (int i = 0; i < 5; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.val[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pins.cleanOut = st_ff.val;
endmodule : ism_pin_sync

// *** hdl/ism_irq_ctrl.sv ***
`timescale 1ns/10ps
`include "ism_consts.svh"
module ism_irq_ctrl
    import ism_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins
    input  wire logic        extPin0,
    input  wire logic        extPin1,
    input  wire logic        rxPin,
    input  wire logic        lowSupplyRaw,
    input  wire logic        slowOscClk,
    // internal source pulses: tb0 tb1 stmP stmA ctmP ctmA de ur iic spi
    input  wire logic        tb0Evt,
    input  wire logic        tb1Evt,
    input  wire logic        stmPEvt,
    input  wire logic        stmAEvt,
    input  wire logic        ctmPEvt,
    input  wire logic        ctmAEvt,
    input  wire logic        deEvt,
    input  wire logic        urEvt,
    input  wire logic        iicEvt,
    input  wire logic        spiEvt,
    // power state
    input  wire logic        sleepMode,
    input  wire logic        idleMode,
    input  wire logic        serialClkOn,
    // core side
    input  wire logic        stackFull,
    input  wire logic        irqAccept,
    output logic             irqReq,
    output logic      [3:0]  irqVector,
    output logic             wakeUp,
    output logic             monitorOn,
    output logic      [2:0]  tripLevelSel,
    output logic             serialFreeze,
    output logic             rxDiscard
);
    typedef struct packed {
        logic [7:0]  smc;
        logic [7:0]  edgeSel;
        logic [7:0]  pic0;
        logic [7:0]  pic1;
        logic [7:0]  pic2;
        logic [7:0]  gic0;
        logic [7:0]  gic1;
        logic [7:0]  gic2;
        logic [7:0]  gic3;
        logic [7:0]  serCfg;
        logic [4:0]  pinPrev;
        logic [3:0]  lsSync;
        logic [2:0]  dbCnt;
        ism_pwr_t    pwr;
        logic [7:0]  recCnt;
        logic        wakePend;
        logic        ack;
        logic [31:0] rdat;
        logic        req;
        logic [3:0]  vec;
        logic        wake;
    } ism_st_t;

    ism_st_t st_ff;
    ism_st_t nxt_st;

    ism_sync_if syncBus ();
    logic [4:0] pinVal;

    assign syncBus.rawIn = {slowOscClk, lowSupplyRaw, rxPin, extPin1, extPin0};
    assign pinVal        = syncBus.cleanOut;

    ism_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pins    (syncBus)
    );

    function automatic logic edgeHit(input logic [1:0] mode, input logic prev,
                                     input logic cur);
        edgeHit = ((mode[0] & ~prev & cur) | (mode[1] & prev & ~cur));
    endfunction : edgeHit

    function automatic logic [7:0] wrByte(input logic [7:0] old, input logic [7:0] mask);
        wrByte = (old & ~mask) | (wb_dat_i[7:0] & mask);
    endfunction : wrByte

    logic wbWr;
    logic wbHit;
    logic slowRise;
    logic rxFall;
    logic serWakeOk;
    logic lvOut;
    logic [7:0] readMux;
    logic [8:0] pend;

    assign wbHit    = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wbWr     = wbHit & wb_we_i & wb_sel_i[0];
    assign slowRise = st_ff.pinPrev[4] == 1'b0 && pinVal[4] == 1'b1;
    assign rxFall   = st_ff.pinPrev[2] & ~pinVal[2];
    // monitor gated off in sleep
    assign lvOut    = st_ff.smc[`ISM_SMC_EN] & ~sleepMode & pinVal[3];
    // wake, port, receiver, receive-irq enables with serial clock off
    assign serWakeOk = (&st_ff.serCfg[3:0]) & ~serialClkOn;
    // flag and enable pairs, vector 9 at the top down to vector 1
    assign pend = {st_ff.pic2[5] & st_ff.pic2[1], st_ff.pic2[4] & st_ff.pic2[0],
                   st_ff.pic1[7] & st_ff.pic1[3], st_ff.pic1[6] & st_ff.pic1[2],
                   st_ff.pic1[5] & st_ff.pic1[1], st_ff.pic1[4] & st_ff.pic1[0],
                   st_ff.pic0[6] & st_ff.pic0[3], st_ff.pic0[5] & st_ff.pic0[2],
                   st_ff.pic0[4] & st_ff.pic0[1]};

    always_comb begin
        unique case (wb_adr_i)
            `ISM_ADR_SMC:    readMux = st_ff.smc;
            `ISM_ADR_EDGE:   readMux = {4'h0, st_ff.edgeSel[3:0]};
            `ISM_ADR_PIC0:   readMux = st_ff.pic0;
            `ISM_ADR_PIC1:   readMux = st_ff.pic1;
            `ISM_ADR_PIC2:   readMux = st_ff.pic2;
            `ISM_ADR_GIC0:   readMux = st_ff.gic0;
            `ISM_ADR_GIC1:   readMux = st_ff.gic1;
            `ISM_ADR_GIC2:   readMux = st_ff.gic2;
            `ISM_ADR_GIC3:   readMux = st_ff.gic3;
            `ISM_ADR_SERCFG: readMux = st_ff.serCfg;
            `ISM_ADR_STAT:   readMux = {6'h00, st_ff.pwr};
            default:         readMux = 8'h00;
        endcase
    end

    always_comb begin
        logic [7:0] gr;
        gr             = 8'h00;
        nxt_st         = st_ff;
        nxt_st.pinPrev = pinVal;
        nxt_st.ack     = wbHit;
        nxt_st.rdat    = {24'h000000, readMux};
        nxt_st.wake    = 1'b0;

        // register writes first, hardware sets afterwards so a set wins
        if (wbWr) begin
            unique case (wb_adr_i)
                `ISM_ADR_SMC:    nxt_st.smc = wrByte(st_ff.smc, `ISM_SMC_WMASK);
                `ISM_ADR_EDGE:   nxt_st.edgeSel = wrByte(st_ff.edgeSel, `ISM_EDGE_WMASK);
                `ISM_ADR_PIC0:   nxt_st.pic0 = wrByte(st_ff.pic0, `ISM_PIC0_MASK);
                `ISM_ADR_PIC1:   nxt_st.pic1 = wb_dat_i[7:0];
                `ISM_ADR_PIC2:   nxt_st.pic2 = wrByte(st_ff.pic2, `ISM_PIC2_MASK);
                `ISM_ADR_GIC0:   nxt_st.gic0 = wrByte(st_ff.gic0, `ISM_GIC_MASK);
                `ISM_ADR_GIC1:   nxt_st.gic1 = wrByte(st_ff.gic1, `ISM_GIC_MASK);
                `ISM_ADR_GIC2:   nxt_st.gic2 = wrByte(st_ff.gic2, `ISM_GIC_MASK);
                `ISM_ADR_GIC3:   nxt_st.gic3 = wrByte(st_ff.gic3, `ISM_GIC_MASK);
                `ISM_ADR_SERCFG: nxt_st.serCfg = wrByte(st_ff.serCfg, `ISM_SER_MASK);
                default: ;
            endcase
        end

        // read-only low supply flag follows the comparator
        nxt_st.smc[`ISM_SMC_OUT] = lvOut;

        // debounce counted on slow oscillator rising edges
        if (!lvOut) begin
            nxt_st.dbCnt = 3'h0;
        end else if (slowRise && st_ff.dbCnt != 3'(`ISM_DEBOUNCE_LS)) begin
            nxt_st.dbCnt = st_ff.dbCnt + 3'h1;
        end
        if (lvOut && slowRise && st_ff.dbCnt == 3'(`ISM_DEBOUNCE_LS - 1)) begin
            nxt_st.gic2[4] = 1'b1;
        end

        // external pins
        if (edgeHit(st_ff.edgeSel[1:0], st_ff.pinPrev[0], pinVal[0])) begin
            nxt_st.pic0[4] = 1'b1;
        end
        if (edgeHit(st_ff.edgeSel[3:2], st_ff.pinPrev[1], pinVal[1])) begin
            nxt_st.pic0[5] = 1'b1;
        end
        // internal sources, each to its own flag
        if (tb0Evt)  nxt_st.pic0[6] = 1'b1;
        if (tb1Evt)  nxt_st.pic1[4] = 1'b1;
        if (spiEvt)  nxt_st.pic2[5] = 1'b1;
        if (stmPEvt) nxt_st.gic0[4] = 1'b1;
        if (stmAEvt) nxt_st.gic0[5] = 1'b1;
        if (ctmPEvt) nxt_st.gic1[4] = 1'b1;
        if (ctmAEvt) nxt_st.gic1[5] = 1'b1;
        if (deEvt)   nxt_st.gic2[5] = 1'b1;
        if (iicEvt)  nxt_st.gic3[5] = 1'b1;
        // serial events ignored while recovering from wake-up
        if (urEvt && st_ff.pwr == ISM_RUN) nxt_st.gic3[4] = 1'b1;

        // power sequencing for the serial wake path
        unique case (st_ff.pwr)
            ISM_RUN: begin
                if (sleepMode) nxt_st.pwr = ISM_ASLEEP;
            end
            ISM_ASLEEP: begin
                if (serWakeOk && rxFall) begin
                    nxt_st.wake     = 1'b1;
                    nxt_st.wakePend = 1'b1;
                    nxt_st.pwr      = ISM_RECOVER;
                    nxt_st.recCnt   = 8'(`ISM_RECOVER_CYC);
                end else if (!sleepMode) begin
                    nxt_st.pwr = ISM_RUN;
                end
            end
            ISM_RECOVER: begin
                if (st_ff.recCnt == 8'h01) begin
                    nxt_st.pwr = ISM_RUN;
                    // serial flag only after recovery; gated later by enables
                    if (st_ff.wakePend) nxt_st.gic3[4] = 1'b1;
                    nxt_st.wakePend = 1'b0;
                end
                nxt_st.recCnt = st_ff.recCnt - 8'h01;
            end
            default: nxt_st.pwr = ISM_RUN;
        endcase

        // group flags from enabled members
        for (int g = 0; g < 4; g++) begin
            gr = (g == 0) ? nxt_st.gic0 : (g == 1) ? nxt_st.gic1 :
                 (g == 2) ? nxt_st.gic2 : nxt_st.gic3;
            if ((gr[4] & gr[0]) | (gr[5] & gr[1])) begin
                if (g < 3) nxt_st.pic1[5 + g] = 1'b1;
                else       nxt_st.pic2[4] = 1'b1;
            end
        end

        // idle wake only from a newly set supply flag, no other pending flag
        if (idleMode && (nxt_st.gic2[4] && !st_ff.gic2[4])) begin
            nxt_st.wake = 1'b1;
        end

        // vector selection by priority
        nxt_st.req = 1'b0;
        nxt_st.vec = 4'h0;
        if (st_ff.pic0[0] && !stackFull) begin
            // walk up from the weakest source so the lowest vector wins
            for (int v = 8; v >= 0; v--) begin
                if (pend[v]) begin
                    nxt_st.req = 1'b1;
                    nxt_st.vec = 4'(v + 1);
                end
            end
        end
        if (irqAccept && st_ff.req) begin
            nxt_st.pic0[0] = 1'b0;
            nxt_st.req     = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff     <= '0;
            st_ff.pwr <= ISM_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o     = st_ff.rdat;
    assign wb_ack_o     = st_ff.ack;
    assign irqReq       = st_ff.req;
    assign irqVector    = st_ff.vec;
    assign wakeUp       = st_ff.wake;
    assign monitorOn    = st_ff.smc[`ISM_SMC_EN] & ~sleepMode;
    assign tripLevelSel = st_ff.smc[2:0];
    // transmitter freezes while its clock is off or while the power state is not run
    assign serialFreeze = ~serialClkOn | (st_ff.pwr != ISM_RUN);
    assign rxDiscard    = st_ff.pwr == ISM_RECOVER;

    // assertions
    property p_edgeUpper;
        @(posedge ref_clk) disable iff (rst)
        st_ff.edgeSel[7:4] == 4'h0;
    endproperty
    a_edgeUpper: assert property (p_edgeUpper) else $error("edge upper nibble set");

    property p_noGlobal;
        @(posedge ref_clk) disable iff (rst)
        !st_ff.pic0[0] |=> !irqReq;
    endproperty
    a_noGlobal: assert property (p_noGlobal)
        else $error("request without global enable");

    property p_accClears;
        @(posedge ref_clk) disable iff (rst)
        (irqAccept && irqReq) |=> !st_ff.pic0[0];
    endproperty
    a_accClears: assert property (p_accClears)
        else $error("global enable not cleared");

    property p_stackHold;
        @(posedge ref_clk) disable iff (rst)
        stackFull |=> !irqReq;
    endproperty
    a_stackHold: assert property (p_stackHold) else $error("request with full stack");

    property p_sleepOff;
        @(posedge ref_clk) disable iff (rst)
        sleepMode |-> !monitorOn;
    endproperty
    a_sleepOff: assert property (p_sleepOff) else $error("monitor on in sleep");

    property p_lvFlagNeedsOut;
        @(posedge ref_clk) disable iff (rst)
        ($rose(st_ff.gic2[4]) && !$past(wbWr)) |-> $past(st_ff.smc[`ISM_SMC_OUT]);
    endproperty
    a_lvFlagNeedsOut: assert property (p_lvFlagNeedsOut)
        else $error("supply flag early");

    property p_recoverDiscard;
        @(posedge ref_clk) disable iff (rst)
        $rose(rxDiscard) |-> rxDiscard [*8];
    endproperty
    a_recoverDiscard: assert property (p_recoverDiscard)
        else $error("recovery too short");

    property p_ackOnce;
        @(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackOnce: assert property (p_ackOnce) else $error("ack held two cycles");

    property p_recoverHold;
        @(posedge ref_clk) disable iff (rst)
        (rxDiscard && st_ff.recCnt != 8'h01 && !wbWr) |=> $stable(st_ff.gic3[4]);
    endproperty
    a_recoverHold: assert property (p_recoverHold)
        else $error("serial flag set in recovery");

    property p_sleepFlag;
        @(posedge ref_clk) disable iff (rst)
        sleepMode |=> !st_ff.smc[`ISM_SMC_OUT];
    endproperty
    a_sleepFlag: assert property (p_sleepFlag)
        else $error("low supply flag in sleep");
endmodule : ism_irq_ctrl

// *** tb/ism_core_model.sv ***
`timescale 1ns/10ps
module ism_core_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // request from controller, slow-answer mode from the testbench
    input  wire logic       irqReq,
    input  wire logic [3:0] irqVector,
    input  wire logic       slowMode,
    // answer to controller
    output logic            irqAccept,
    output logic      [3:0] acceptVec
);
    logic [2:0] lagCnt;
    logic [2:0] holdCnt;
    // takes only a standing request, one at a time, promptly or late
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqAccept <= 1'b0;
            acceptVec <= 4'h0;
            lagCnt    <= 3'h0;
            holdCnt   <= 3'h0;
        end else begin
            irqAccept <= 1'b0;
            if (holdCnt != 3'h0) begin
                holdCnt <= holdCnt - 3'h1;
            end else if (irqReq !== 1'b1) begin
                lagCnt <= slowMode ? 3'h3 : 3'h0;
            end else if (lagCnt != 3'h0) begin
                lagCnt <= lagCnt - 3'h1;
            end else begin
                irqAccept <= 1'b1;
                acceptVec <= irqVector;
                holdCnt   <= 3'h4;
            end
        end
    end
endmodule : ism_core_model

// *** tb/ism_irq_ctrl_tb.sv ***
`timescale 1ns/10ps
`include "ism_consts.svh"
module ism_irq_ctrl_tb
    import ism_pkg::*;
;
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, irqReq, wakeUp, monitorOn, serialFreeze, rxDiscard, irqAccept;
    logic [3:0]  irqVector, acceptVec, expV;
    logic [2:0]  tripLevelSel;
    logic [1:0]  extPins = 2'h0;
    logic        rxPin = 1'b1, lowSupplyRaw = 1'b0, slowOscClk = 1'b0, slowMode = 1'b0;
    logic        sleepMode = 1'b0, idleMode = 1'b0, serialClkOn = 1'b1, stackFull = 1'b0;
    logic [9:0]  evt = 10'h0;
    wire         extPin0, extPin1, tb0Evt, tb1Evt, stmPEvt, stmAEvt, ctmPEvt, ctmAEvt;
    wire         deEvt, urEvt, iicEvt, spiEvt;
    logic [7:0]  rdQ[$];
    logic [3:0]  vecQ[$];
    logic [7:0]  expB, rnd;
    logic [7:0]  grpEn[4] = '{8'h02, 8'h01, 8'h02, 8'h01};
    int          grpEvt[4] = '{3, 4, 6, 7};
    int          n_mismatch = 0, num_checks = 0, wakeCnt = 0, wakeBase, seed = 18134;

    assign {extPin1, extPin0} = extPins;
    assign {spiEvt, iicEvt, urEvt, deEvt, ctmAEvt, ctmPEvt, stmAEvt, stmPEvt, tb1Evt,
            tb0Evt} = evt;

    ism_irq_ctrl dut_u (
        .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_dat_o, .wb_ack_o, .extPin0, .extPin1, .rxPin, .lowSupplyRaw, .slowOscClk,
        .tb0Evt, .tb1Evt, .stmPEvt, .stmAEvt, .ctmPEvt, .ctmAEvt, .deEvt, .urEvt, .iicEvt,
        .spiEvt, .sleepMode, .idleMode, .serialClkOn, .stackFull, .irqAccept, .irqReq,
        .irqVector, .wakeUp, .monitorOn, .tripLevelSel, .serialFreeze, .rxDiscard
    );
    ism_core_model core_u (
        .ref_clk, .rst, .irqReq, .irqVector, .slowMode, .irqAccept, .acceptVec
    );

    always #12.5 ref_clk = ~ref_clk;
    always begin
        repeat (10) @(posedge ref_clk);
        slowOscClk <= ~slowOscClk;
    end

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle; for a read, dat is the expected byte
    task automatic wbCyc(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                         input logic [3:0] sel = 4'h1);
        if (!we) rdQ.push_back(dat);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= we ? {24'h0, dat} : 32'h0;
        wb_sel_i <= sel;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wbCyc

    task automatic waitCy(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : waitCy

    task automatic pulse(input int idx);
        @(posedge ref_clk);
        evt[idx] <= 1'b1;
        @(posedge ref_clk);
        evt <= 10'h0;
    endtask : pulse

    // compares read data and accepted vectors against the oldest note
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            expB = (rdQ.size() > 0) ? rdQ.pop_front() : 8'hXX;
            chk(wb_dat_o, {24'h0, expB});
        end
        if (irqAccept === 1'b1) begin
            expV = (vecQ.size() > 0) ? vecQ.pop_front() : 4'hF;
            chk({28'h0, acceptVec}, {28'h0, expV});
        end
        if (wakeUp === 1'b1) wakeCnt++;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) wbCyc(1'b0, 8'(i * 4), 8'h00);
        wbCyc(1'b1, 8'h40, 8'hFF);
        wbCyc(1'b0, 8'h40, 8'h00);
        rnd = 8'($random(seed));
        wbCyc(1'b1, `ISM_ADR_EDGE, rnd);
        wbCyc(1'b0, `ISM_ADR_EDGE, rnd & 8'h0F);
        wbCyc(1'b1, `ISM_ADR_EDGE, ~rnd, 4'hE);
        wbCyc(1'b0, `ISM_ADR_EDGE, rnd & 8'h0F);
        for (int c = 0; c < 8; c++) begin
            wbCyc(1'b1, `ISM_ADR_SMC, 8'hF8 | 8'(c));
            wbCyc(1'b0, `ISM_ADR_SMC, 8'h10 | 8'(c));
            chk({29'h0, tripLevelSel}, 32'(c));
            chk({31'h0, monitorOn}, 32'h1);
        end
        sleepMode <= 1'b1;
        waitCy(2);
        chk({31'h0, monitorOn}, 32'h0);
        sleepMode <= 1'b0;
        // every edge mode on both pins
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wbCyc(1'b1, `ISM_ADR_EDGE, 8'(m << (2 * p)));
                wbCyc(1'b1, `ISM_ADR_PIC0, 8'h00);
                extPins[p] <= 1'b1;
                waitCy(8);
                wbCyc(1'b0, `ISM_ADR_PIC0, m[0] ? 8'h10 << p : 8'h00);
                wbCyc(1'b1, `ISM_ADR_PIC0, 8'h00);
                extPins[p] <= 1'b0;
                waitCy(8);
                wbCyc(1'b0, `ISM_ADR_PIC0, m[1] ? 8'h10 << p : 8'h00);
            end
        end
        wbCyc(1'b1, `ISM_ADR_EDGE, 8'h00);
        // masked source, vectoring, nesting block, full stack with a slow core
        wbCyc(1'b1, `ISM_ADR_PIC0, 8'h01);
        pulse(0);
        waitCy(4);
        chk({31'h0, irqReq}, 32'h0);
        wbCyc(1'b0, `ISM_ADR_PIC0, 8'h41);
        vecQ.push_back(4'h3);
        wbCyc(1'b1, `ISM_ADR_PIC0, 8'h49);
        waitCy(8);
        wbCyc(1'b1, `ISM_ADR_PIC1, 8'h01);
        pulse(1);
        waitCy(8);
        chk({31'h0, irqReq}, 32'h0);
        wbCyc(1'b0, `ISM_ADR_PIC1, 8'h11);
        stackFull <= 1'b1;
        slowMode <= 1'b1;
        wbCyc(1'b1, `ISM_ADR_PIC0, 8'h01);
        waitCy(8);
        chk({31'h0, irqReq}, 32'h0);
        vecQ.push_back(4'h4);
        stackFull <= 1'b0;
        waitCy(12);
        slowMode <= 1'b0;
        // group members reach the core through their group vector
        for (int g = 0; g < 4; g++) begin
            wbCyc(1'b1, `ISM_ADR_PIC1, g < 3 ? 8'h02 << g : 8'h00);
            wbCyc(1'b1, `ISM_ADR_PIC2, g == 3 ? 8'h01 : 8'h00);
            wbCyc(1'b1, `ISM_ADR_GIC0 + 8'(4 * g), grpEn[g]);
            wbCyc(1'b1, `ISM_ADR_PIC0, 8'h01);
            vecQ.push_back(4'(5 + g));
            pulse(grpEvt[g]);
            waitCy(10);
            wbCyc(1'b0, `ISM_ADR_GIC0 + 8'(4 * g), grpEn[g] | (grpEn[g] << 4));
            wbCyc(1'b1, `ISM_ADR_GIC0 + 8'(4 * g), 8'h00);
        end
        wbCyc(1'b1, `ISM_ADR_PIC2, 8'h00);
        // supply flag debounce and idle wake
        wbCyc(1'b1, `ISM_ADR_GIC2, 8'h01);
        wbCyc(1'b1, `ISM_ADR_SMC, 8'h13);
        wakeBase = wakeCnt;
        idleMode <= 1'b1;
        lowSupplyRaw <= 1'b1;
        waitCy(6);
        wbCyc(1'b0, `ISM_ADR_SMC, 8'h33);
        wbCyc(1'b0, `ISM_ADR_GIC2, 8'h01);
        waitCy(120);
        wbCyc(1'b0, `ISM_ADR_GIC2, 8'h11);
        chk(32'(wakeCnt - wakeBase), 32'h1);
        lowSupplyRaw <= 1'b0;
        idleMode <= 1'b0;
        wbCyc(1'b1, `ISM_ADR_GIC2, 8'h00);
        // receive pin wake-up and recovery window
        wbCyc(1'b1, `ISM_ADR_SERCFG, 8'h0F);
        wbCyc(1'b0, `ISM_ADR_SERCFG, 8'h0F);
        serialClkOn <= 1'b0;
        sleepMode <= 1'b1;
        waitCy(2);
        chk({31'h0, serialFreeze}, 32'h1);
        wakeBase = wakeCnt;
        rxPin <= 1'b0;
        waitCy(7);
        sleepMode <= 1'b0;
        chk(32'(wakeCnt - wakeBase), 32'h1);
        chk({31'h0, rxDiscard}, 32'h1);
        pulse(7);
        wbCyc(1'b0, `ISM_ADR_GIC3, 8'h00);
        rxPin <= 1'b1;
        waitCy(50);
        chk({31'h0, rxDiscard}, 32'h0);
        wbCyc(1'b0, `ISM_ADR_GIC3, 8'h10);
        chk({31'h0, irqReq}, 32'h0);
        vecQ.push_back(4'h8);
        wbCyc(1'b1, `ISM_ADR_GIC3, 8'h11);
        wbCyc(1'b1, `ISM_ADR_PIC2, 8'h01);
        waitCy(2);
        chk({31'h0, irqReq}, 32'h0);
        wbCyc(1'b1, `ISM_ADR_PIC0, 8'h01);
        waitCy(8);
        serialClkOn <= 1'b1;
        chk(32'(vecQ.size()), 32'h0);
        final_report();
    end
endmodule : ism_irq_ctrl_tb
